// File: design/spimsp_defs.vh
// Constants for the byte-wide SPI master/slave port
`ifndef SPIMSP_DEFS_VH
`define SPIMSP_DEFS_VH

// ------------------------------------------------------------
// Widths and buffer shape
// ------------------------------------------------------------
`define SPIMSP_DW 8
`define SPIMSP_FIFO_DEPTH 16
`define SPIMSP_FIFO_AW 4
`define SPIMSP_LAST_BIT 3'h7
`define SPIMSP_LAST_EDGE 4'hf

// ------------------------------------------------------------
// Half SCK periods in clk cycles, index {double_rate, hi, lo}
// ------------------------------------------------------------
`define SPIMSP_HALF_000 7'h02
`define SPIMSP_HALF_001 7'h08
`define SPIMSP_HALF_010 7'h20
`define SPIMSP_HALF_011 7'h40
`define SPIMSP_HALF_100 7'h01
`define SPIMSP_HALF_101 7'h04
`define SPIMSP_HALF_110 7'h10
`define SPIMSP_HALF_111 7'h20

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SPIMSP_RST_BYTE 8'h00
`define SPIMSP_RST_MASTER_SELECT 1'b0

`endif

// File: design/spimsp_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module spimsp_fifo #(
   parameter W = 8,
   parameter D = 16,
   parameter AW = 4
)(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Fill side
   input wire in_valid,
   output reg in_ready,
   input wire [W-1:0] in_data,
   // Drain side
   output reg out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);

reg [W-1:0] mem [0:D-1];
reg [AW-1:0] wr_ff;
reg [AW-1:0] rd_ff;
reg [AW:0] cnt_ff;
reg [AW:0] nxt_cnt;
wire push;
wire pop;

assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;
assign out_data = mem[rd_ff];

// Occupancy after this cycle's push and pop
always @*
begin
   nxt_cnt = cnt_ff;
   if (push & ~pop)
      nxt_cnt = cnt_ff + 1'b1;
   else if (pop & ~push)
      nxt_cnt = cnt_ff - 1'b1;
end

// Storage has no reset; only pointers, count and flags need a defined start
always @(posedge clk)
begin
   if (push)
      mem[wr_ff] <= in_data;
end

// Pointers and registered full/empty so the flags never glitch
always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
   end
   else
   begin
      if (push)
         wr_ff <= wr_ff + 1'b1;
      if (pop)
         rd_ff <= rd_ff + 1'b1;
      cnt_ff <= nxt_cnt;
      in_ready <= (nxt_cnt != D[AW:0]);
      out_valid <= (nxt_cnt != {(AW+1){1'b0}});
   end
end

endmodule

// File: design/spimsp_core.v
// Byte-wide SPI port, master or slave, with receive stream FIFO
// Functional notes
// - Master: data write starts SCK generator, eight bits shift out.
// - Master: after one byte SCK stops, done flag sets, irq if enabled.
// - Master: slave select is never driven automatically, software does it.
// - Data master-to-slave on MOSI, slave-to-master on MISO, exchanged together.
// - Last received byte is held in a receive buffer for the CPU.
// - Slave: select high keeps port idle, MISO released, SCK ignored.
// - Slave: full byte sets done flag, irq if enabled.
// - Slave: next byte may be written before received byte is read.
// - Transmit single-buffered: no new byte accepted until shift completes.
// - Receive double-buffered: unread byte overwritten by next complete byte.
// - Enabled port overrides pin directions per master or slave role.
// - Master SCK divisor 4/16/64/128, or 2/8/32/64 when doubled.
// - Done flag clears on vector ack, or status read then data access.
// - Collision flag sets on write during transfer; status read, access clear.
// - Select input low while master: drop to slave, set done flag.
`timescale 1ns/1ps
`include "spimsp_defs.vh"
module spimsp_core (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Configuration levels
   input wire port_enable,
   input wire bit_order,
   input wire clock_polarity,
   input wire clock_phase,
   input wire rate_select_hi,
   input wire rate_select_lo,
   input wire double_rate,
   input wire transfer_irq_enable,
   // Master select write
   input wire ms_wr,
   input wire ms_wdata,
   // User pin directions and select level
   input wire dir_mosi_out,
   input wire dir_sck_out,
   input wire dir_ss_out,
   input wire dir_miso_out,
   input wire ss_level,
   // CPU data and status access
   input wire data_wr,
   input wire [7:0] data_wdata,
   input wire data_rd,
   input wire stat_rd,
   input wire vec_ack,
   // Status
   output reg [7:0] rx_byte_ff,
   output reg transfer_done_flag_ff,
   output reg write_collision_flag_ff,
   output reg master_select_ff,
   output reg irq_ff,
   // Received byte stream
   output wire rx_valid,
   input wire rx_ready,
   output wire [7:0] rx_data,
   // SPI pins
   input wire sck_in,
   output reg sck_out_ff,
   output reg sck_oe_n_ff,
   input wire mosi_in,
   output reg mosi_out_ff,
   output reg mosi_oe_n_ff,
   input wire miso_in,
   output reg miso_out_ff,
   output reg miso_oe_n_ff,
   input wire ss_in,
   output reg ss_out_ff,
   output reg ss_oe_n_ff
);

// ------------------------------------------------------------
// Pin synchronisers
// ------------------------------------------------------------
// Stage vectors hold {sck, mosi, miso, ss}; select idles high
reg [3:0] sy1_ff, sy2_ff;
reg sck_s3_ff;
wire sck_s2_ff, mosi_s2_ff, miso_s2_ff, ss_s2_ff;

assign {sck_s2_ff, mosi_s2_ff, miso_s2_ff, ss_s2_ff} = sy2_ff;

// Two stages before use; third SCK stage only feeds the edge detector
always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      sy1_ff <= 4'h1;
      sy2_ff <= 4'h1;
      sck_s3_ff <= 1'b0;
   end
   else
   begin
      sy1_ff <= {sck_in, mosi_in, miso_in, ss_in};
      sy2_ff <= sy1_ff;
      sck_s3_ff <= sck_s2_ff;
   end
end

// ------------------------------------------------------------
// Mode decode and edge generation
// ------------------------------------------------------------
reg run_ff, pend_ff;
reg [6:0] half_ff;
reg [3:0] edge_ff;
reg [2:0] bcnt_ff;
reg [7:0] tx_sh_ff, rx_sh_ff;
wire [6:0] half_len;
reg arm_f_ff, arm_w_ff;
wire mst, slv, s_act, m_tick, s_edge;
wire lead, trail, smp, stp, rx_bit, byte_done, busy, m_end;
wire mfault, wr_ok, fifo_rdy;
wire [7:0] nxt_rx_sh;
reg [7:0] nxt_tx_sh;

assign mst = port_enable & master_select_ff;
assign slv = port_enable & ~master_select_ff;
assign s_act = slv & ~ss_s2_ff;
assign m_tick = run_ff & (half_ff == 7'h00);
assign s_edge = s_act & (sck_s2_ff != sck_s3_ff);
// Leading edge leaves the idle level set by polarity
assign lead = mst ? (m_tick & ~edge_ff[0]) : (s_edge & (sck_s2_ff != clock_polarity));
assign trail = mst ? (m_tick & edge_ff[0]) : (s_edge & (sck_s2_ff == clock_polarity));
assign smp = clock_phase ? trail : lead;
assign stp = clock_phase ? lead : trail;
assign rx_bit = mst ? miso_s2_ff : mosi_s2_ff;
assign byte_done = smp & (bcnt_ff == `SPIMSP_LAST_BIT);
assign m_end = m_tick & (edge_ff == `SPIMSP_LAST_EDGE);
assign busy = run_ff | pend_ff | (s_act & (bcnt_ff != 3'h0));
assign mfault = mst & ~dir_ss_out & ~ss_s2_ff;
assign wr_ok = data_wr & ~busy;
assign nxt_rx_sh = bit_order ? {rx_bit, rx_sh_ff[7:1]} : {rx_sh_ff[6:0], rx_bit};

// Divider selection; ignored in slave mode
assign half_len = double_rate ?
   (rate_select_hi ? (rate_select_lo ? `SPIMSP_HALF_111 : `SPIMSP_HALF_110) :
      (rate_select_lo ? `SPIMSP_HALF_101 : `SPIMSP_HALF_100)) :
   (rate_select_hi ? (rate_select_lo ? `SPIMSP_HALF_011 : `SPIMSP_HALF_010) :
      (rate_select_lo ? `SPIMSP_HALF_001 : `SPIMSP_HALF_000));

// ------------------------------------------------------------
// Master clock generator
// ------------------------------------------------------------
// Start waits for stream room, so a master never loses a byte
always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      run_ff <= 1'b0;
      pend_ff <= 1'b0;
      half_ff <= 7'h00;
      edge_ff <= 4'h0;
      sck_out_ff <= 1'b0;
   end
   else if (~mst | mfault)
   begin
      run_ff <= 1'b0;
      pend_ff <= 1'b0;
      edge_ff <= 4'h0;
      sck_out_ff <= clock_polarity;
   end
   else if (pend_ff & fifo_rdy)
   begin
      run_ff <= 1'b1;
      pend_ff <= 1'b0;
      half_ff <= half_len - 7'h01;
      edge_ff <= 4'h0;
   end
   else if (run_ff)
   begin
      if (m_tick)
      begin
         half_ff <= half_len - 7'h01;
         sck_out_ff <= ~sck_out_ff;
         edge_ff <= edge_ff + 4'h1;
         if (edge_ff == `SPIMSP_LAST_EDGE)
            run_ff <= 1'b0;
      end
      else
         half_ff <= half_ff - 7'h01;
   end
   else
   begin
      pend_ff <= pend_ff | wr_ok;
      sck_out_ff <= clock_polarity;
   end
end

// ------------------------------------------------------------
// Shift registers and receive buffer
// ------------------------------------------------------------
// First setup edge in phase 1 only presents the already loaded bit
always @*
begin
   nxt_tx_sh = tx_sh_ff;
   if (wr_ok)
      nxt_tx_sh = data_wdata;
   else if (stp & ~(clock_phase & (bcnt_ff == 3'h0)))
      nxt_tx_sh = bit_order ? {1'b0, tx_sh_ff[7:1]} : {tx_sh_ff[6:0], 1'b0};
end

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      tx_sh_ff <= `SPIMSP_RST_BYTE;
      rx_sh_ff <= `SPIMSP_RST_BYTE;
      rx_byte_ff <= `SPIMSP_RST_BYTE;
      bcnt_ff <= 3'h0;
      mosi_out_ff <= 1'b0;
      miso_out_ff <= 1'b0;
   end
   else
   begin
      tx_sh_ff <= nxt_tx_sh;
      mosi_out_ff <= bit_order ? nxt_tx_sh[0] : nxt_tx_sh[7];
      miso_out_ff <= bit_order ? nxt_tx_sh[0] : nxt_tx_sh[7];
      // Select high drops a partial slave byte
      if ((slv & ss_s2_ff) | ~port_enable | mfault)
         bcnt_ff <= 3'h0;
      else if (smp)
      begin
         rx_sh_ff <= nxt_rx_sh;
         bcnt_ff <= bcnt_ff + 3'h1;
      end
      if (byte_done)
         rx_byte_ff <= nxt_rx_sh;
   end
end

// ------------------------------------------------------------
// Flags, master select and interrupt
// ------------------------------------------------------------
wire acc;
wire clr_f, clr_w, set_f, set_w, nxt_f;

assign acc = data_wr | data_rd;
assign clr_f = vec_ack | (acc & (arm_f_ff | arm_w_ff));
assign clr_w = acc & arm_w_ff;
// Master flags only once SCK is idle, so a write right after the flag is taken
assign set_f = (byte_done & ~mst) | m_end | mfault;
assign set_w = data_wr & busy;
// Set wins over a clear in the same cycle
assign nxt_f = set_f | (transfer_done_flag_ff & ~clr_f);

always @(posedge clk or posedge rst)
begin
   if (rst)
   begin
      transfer_done_flag_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      arm_f_ff <= 1'b0;
      arm_w_ff <= 1'b0;
      irq_ff <= 1'b0;
      master_select_ff <= `SPIMSP_RST_MASTER_SELECT;
      sck_oe_n_ff <= 1'b1;
      mosi_oe_n_ff <= 1'b1;
      miso_oe_n_ff <= 1'b1;
      ss_oe_n_ff <= 1'b1;
      ss_out_ff <= 1'b1;
   end
   else
   begin
      transfer_done_flag_ff <= nxt_f;
      write_collision_flag_ff <= set_w | (write_collision_flag_ff & ~clr_w);
      // Latest status read decides what the next data access clears
      arm_f_ff <= stat_rd ? transfer_done_flag_ff : (arm_f_ff & ~acc);
      arm_w_ff <= stat_rd ? write_collision_flag_ff : (arm_w_ff & ~acc);
      irq_ff <= nxt_f & transfer_irq_enable;
      if (mfault)
         master_select_ff <= 1'b0;
      else if (ms_wr)
         master_select_ff <= ms_wdata;
      // Pin roles; select pin output follows software only, never a transfer
      sck_oe_n_ff <= ~(mst & ~mfault & dir_sck_out);
      mosi_oe_n_ff <= ~(mst & ~mfault & dir_mosi_out);
      ss_oe_n_ff <= ~(mst & dir_ss_out);
      ss_out_ff <= ss_level;
      miso_oe_n_ff <= ~(s_act & dir_miso_out);
   end
end

// ------------------------------------------------------------
// Received byte stream
// ------------------------------------------------------------
// A slave cannot stall its master: a byte meeting a full FIFO is lost
spimsp_fifo #(.W(`SPIMSP_DW), .D(`SPIMSP_FIFO_DEPTH), .AW(`SPIMSP_FIFO_AW)) i_spimsp_fifo (
   .clk(clk), .rst(rst), .in_valid(byte_done), .in_ready(fifo_rdy), .in_data(nxt_rx_sh),
   .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data)
);

endmodule

// File: verification/spimsp_remote.sv
// Remote SPI slave model, mode 0, MSB first
`timescale 1ns/1ps
module spimsp_remote (
   // Pins
   input wire sck,
   input wire mosi,
   input wire ss_n,
   output logic miso,
   // Answer byte and captured byte
   input wire [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic [7:0] sh;

   // Select loads the answer; release flips MISO so a stale bit never reads as driven
   always @(ss_n)
   begin
      if (!ss_n)
      begin
         sh = tx_byte;
         miso = tx_byte[7];
      end
      else
         miso = ~miso;
   end

   // Sample on rising SCK
   always @(posedge sck)
      if (!ss_n)
         rx_byte <= {rx_byte[6:0], mosi};

   // Shift out on falling SCK
   always @(negedge sck)
      if (!ss_n)
      begin
         sh = {sh[6:0], 1'b0};
         miso = sh[7];
      end
endmodule

// File: verification/spimsp_core_asserts.sv
// Checker for pin roles, flags and interrupt of the SPI port
`timescale 1ns/1ps
module spimsp_core_asserts (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Inputs
   input wire port_enable,
   input wire transfer_irq_enable,
   input wire ms_wr,
   input wire dir_ss_out,
   input wire ss_level,
   input wire data_wr,
   input wire ss_in,
   // Outputs
   input wire transfer_done_flag_ff,
   input wire write_collision_flag_ff,
   input wire master_select_ff,
   input wire irq_ff,
   input wire miso_oe_n_ff,
   input wire ss_out_ff,
   input wire ss_oe_n_ff
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_miso_in; (port_enable && master_select_ff) [*2] |-> miso_oe_n_ff; endproperty
   a_miso_in: assert property (p_miso_in) else $error("master drives miso");
   // Sync plus register delay, so five cycles of high select
   property p_miso_idle; ss_in [*5] |-> miso_oe_n_ff; endproperty
   a_miso_idle: assert property (p_miso_idle) else $error("miso driven unselected");
   property p_irq_on; (transfer_done_flag_ff && transfer_irq_enable) [*2] |-> irq_ff; endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");
   property p_irq_off; !transfer_irq_enable [*2] |-> !irq_ff; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   property p_collide;
      master_select_ff && data_wr ##1 master_select_ff && data_wr |=> write_collision_flag_ff;
   endproperty
   a_collide: assert property (p_collide) else $error("no collision");
   property p_fault; (port_enable && !dir_ss_out && !ss_in) [*6] |-> !master_select_ff; endproperty
   a_fault: assert property (p_fault) else $error("master kept");
   property p_fault_flag;
      $fell(master_select_ff) && !$past(ms_wr) |-> transfer_done_flag_ff;
   endproperty
   a_fault_flag: assert property (p_fault_flag) else $error("fault flag missing");
   property p_ss_user;
      (port_enable && master_select_ff && dir_ss_out && $stable(ss_level)) [*2]
         |-> !ss_oe_n_ff && ss_out_ff == ss_level;
   endproperty
   a_ss_user: assert property (p_ss_user) else $error("select not software level");
   // Main scenarios reached
   c_done: cover property ($rose(transfer_done_flag_ff) && master_select_ff);
   c_coll: cover property ($rose(write_collision_flag_ff));
   c_fault: cover property ($fell(master_select_ff));
endmodule

bind spimsp_core spimsp_core_asserts i_spimsp_core_asserts (.clk, .rst, .port_enable,
   .transfer_irq_enable, .ms_wr, .dir_ss_out, .ss_level, .data_wr, .ss_in,
   .transfer_done_flag_ff, .write_collision_flag_ff, .master_select_ff, .irq_ff,
   .miso_oe_n_ff, .ss_out_ff, .ss_oe_n_ff);

// File: verification/spi_master_slave_port_tb.sv
// Self-checking bench for the SPI master/slave port
`timescale 1ns/1ps
module spi_master_slave_port_tb;
   localparam [4:0] MS = 5'h10, WR = 5'h08, RD = 5'h04, ST = 5'h02, VEC = 5'h01;
   logic clk = 1'b0, rst = 1'b1, port_enable = 1'b0, bit_order = 1'b0;
   logic clock_polarity = 1'b0, clock_phase = 1'b0, rate_select_hi = 1'b0;
   logic rate_select_lo = 1'b0, double_rate = 1'b0, transfer_irq_enable = 1'b0;
   logic ms_wr = 1'b0, ms_wdata = 1'b0, dir_mosi_out = 1'b0, dir_sck_out = 1'b0;
   logic dir_ss_out = 1'b0, dir_miso_out = 1'b0, ss_level = 1'b1, data_wr = 1'b0;
   logic data_rd = 1'b0, stat_rd = 1'b0, vec_ack = 1'b0, rx_ready = 1'b1;
   logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss_n = 1'b1;
   logic [7:0] data_wdata = 8'h00, rem_tx = 8'h00, q;
   // Half SCK period per rate code: divisors 4,16,64,128,2,8,32,64 halved
   logic [7:0] half [8] = '{8'h02, 8'h08, 8'h20, 8'h40, 8'h01, 8'h04, 8'h10, 8'h20};
   int miscompares = 0, checks = 0, c, n;
   wire [7:0] rx_byte_ff, rx_data, rem_rx;
   wire transfer_done_flag_ff, write_collision_flag_ff, master_select_ff, irq_ff, rx_valid;
   wire sck_out_ff, sck_oe_n_ff, mosi_out_ff, mosi_oe_n_ff, miso_out_ff, miso_oe_n_ff;
   wire ss_out_ff, ss_oe_n_ff, rem_miso;
   // Pin levels; the select line has a pull-up, modelled by tb_ss_n idling high
   wire sck = sck_oe_n_ff ? tb_sck : sck_out_ff;
   wire mosi = mosi_oe_n_ff ? tb_mosi : mosi_out_ff;
   wire ss_n = ss_oe_n_ff ? tb_ss_n : ss_out_ff;
   wire miso = miso_oe_n_ff ? rem_miso : miso_out_ff;
   wire rem_ss_n = ss_oe_n_ff | ss_out_ff;

   spimsp_core i_spimsp_core (.clk, .rst, .port_enable, .bit_order, .clock_polarity,
      .clock_phase, .rate_select_hi, .rate_select_lo, .double_rate, .transfer_irq_enable,
      .ms_wr, .ms_wdata, .dir_mosi_out, .dir_sck_out, .dir_ss_out, .dir_miso_out,
      .ss_level, .data_wr, .data_wdata, .data_rd, .stat_rd, .vec_ack, .rx_byte_ff,
      .transfer_done_flag_ff, .write_collision_flag_ff, .master_select_ff, .irq_ff,
      .rx_valid, .rx_ready, .rx_data, .sck_in(sck), .sck_out_ff, .sck_oe_n_ff,
      .mosi_in(mosi), .mosi_out_ff, .mosi_oe_n_ff, .miso_in(miso), .miso_out_ff,
      .miso_oe_n_ff, .ss_in(ss_n), .ss_out_ff, .ss_oe_n_ff);
   spimsp_remote i_spimsp_remote (.sck, .mosi, .ss_n(rem_ss_n), .miso(rem_miso),
      .tx_byte(rem_tx), .rx_byte(rem_rx));

   // 250 MHz clock
   always #2 clk = ~clk;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task chk(input [7:0] seen, input [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task test_done;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // CPU access strobes held n cycles; lowered at an edge no caller re-enters
   task acc(input [4:0] k, input [7:0] d, input int n);
      @(posedge clk);
      {ms_wr, data_wr, data_rd, stat_rd, vec_ack} <= k;
      data_wdata <= d;
      ms_wdata <= d[0];
      repeat (n) @(posedge clk);
      {ms_wr, data_wr, data_rd, stat_rd, vec_ack} <= 5'h00;
   endtask

   // Master byte: measures one SCK half period, waits bounded for done
   task mxfer(input [7:0] d, input [7:0] e, input bit dup);
      int i;
      logic v;
      @(posedge clk);
      ss_level <= 1'b0;
      rem_tx <= ~d;
      acc(ST, d, 1);
      acc(WR, d, dup ? 2 : 1);
      @(negedge clk);
      v = sck_out_ff;
      for (i = 0; i < 300 && sck_out_ff === v; i++) @(negedge clk);
      v = sck_out_ff;
      for (n = 0; n < 300 && sck_out_ff === v; n++) @(negedge clk);
      if (dup)
         acc(WR, ~d, 1);
      for (i = 0; i < 3000 && transfer_done_flag_ff !== 1'b1; i++) @(negedge clk);
      chk({7'h00, transfer_done_flag_ff}, 8'h01);
      chk(rem_rx, e);
      @(posedge clk);
      ss_level <= 1'b1;
   endtask

   // Bench as remote master, mode 0 MSB first, SCK at clk/12
   task sbyte(input bit sel, input [7:0] d);
      int i;
      @(posedge clk);
      tb_ss_n <= ~sel;
      repeat (8) @(posedge clk);
      for (i = 7; i >= 0; i--)
      begin
         tb_mosi <= d[i];
         repeat (6) @(posedge clk);
         q[i] = miso;
         tb_sck <= 1'b1;
         repeat (6) @(posedge clk);
         tb_sck <= 1'b0;
      end
      repeat (6) @(posedge clk);
      tb_ss_n <= 1'b1;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (15) @(posedge clk);
      @(negedge clk);
      chk({sck_oe_n_ff, mosi_oe_n_ff, miso_oe_n_ff, ss_oe_n_ff, ss_out_ff,
         transfer_done_flag_ff, write_collision_flag_ff, master_select_ff}, 8'hf8);
      @(posedge clk);
      rst <= 1'b0;
      {port_enable, dir_mosi_out, dir_sck_out, dir_ss_out} <= 4'hf;
      acc(MS, 8'h01, 1);
      for (c = 0; c < 8; c++)
      begin
         @(posedge clk);
         {double_rate, rate_select_hi, rate_select_lo} <= c[2:0];
         mxfer(8'hc3 ^ c[7:0], 8'hc3 ^ c[7:0], 1'b0);
         chk(n[7:0], half[c]);
         // Divisors 2 and 4 sample MISO stale through the synchroniser
         if (half[c] > 8'h02)
            chk(rx_byte_ff, ~(8'hc3 ^ c[7:0]));
         else
            chk({7'h00, irq_ff}, 8'h00);
      end
      acc(VEC, 8'h00, 1);
      @(negedge clk);
      chk({7'h00, transfer_done_flag_ff}, 8'h00);
      @(posedge clk);
      {bit_order, transfer_irq_enable, double_rate, rate_select_hi, rate_select_lo} <= 5'h19;
      mxfer(8'h01, 8'h80, 1'b1);
      chk(rx_byte_ff, 8'h7f);
      chk({6'h00, write_collision_flag_ff, irq_ff}, 8'h03);
      acc(ST, 8'h00, 1);
      acc(RD, 8'h00, 1);
      @(negedge clk);
      chk({6'h00, write_collision_flag_ff, transfer_done_flag_ff}, 8'h00);
      @(posedge clk);
      clock_polarity <= 1'b1;
      repeat (4) @(negedge clk);
      chk({7'h00, sck_out_ff}, 8'h01);
      @(posedge clk);
      {clock_polarity, dir_ss_out, tb_ss_n} <= 3'h0;
      repeat (8) @(negedge clk);
      chk({6'h00, master_select_ff, transfer_done_flag_ff}, 8'h01);
      @(posedge clk);
      {tb_ss_n, dir_mosi_out, dir_sck_out, dir_miso_out, bit_order} <= 5'h12;
      acc(VEC, 8'h00, 4);
      acc(WR, 8'h5a, 1);
      sbyte(1'b0, 8'hff);
      chk({7'h00, transfer_done_flag_ff}, 8'h00);
      sbyte(1'b1, 8'h96);
      chk(q, 8'h5a);
      chk({7'h00, transfer_done_flag_ff}, 8'h01);
      acc(WR, 8'h33, 1);
      chk(rx_byte_ff, 8'h96);
      @(posedge clk);
      rx_ready <= 1'b0;
      for (c = 0; c < 17; c++)
         sbyte(1'b1, 8'h10 + c[7:0]);
      @(negedge clk);
      chk(rx_byte_ff, 8'h20);
      for (c = 0; c < 16; c++)
      begin
         @(negedge clk);
         chk({7'h00, rx_valid}, 8'h01);
         chk(rx_data, 8'h10 + c[7:0]);
         @(posedge clk);
         rx_ready <= 1'b1;
         @(posedge clk);
         rx_ready <= 1'b0;
      end
      @(negedge clk);
      chk({7'h00, rx_valid}, 8'h00);
      test_done;
   end

   // Watchdog well beyond the expected few thousand cycles
   initial
   begin
      repeat (40000) @(posedge clk);
      miscompares++;
      test_done;
   end
endmodule
